// ---- core/sink_regs_pkg.sv ----
// Package with offsets, field layouts and fixed values of the sink management registers
package sink_regs_pkg;

  // ==========================================================================
  // Bus widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFF_SLAVE_OUTPUT_OVERRIDE = 12'h0ef0;
  localparam logic [11:0] OFF_SLAVE_TRACE_ID_CAPTURE = 12'h0ef4;
  localparam logic [11:0] OFF_SLAVE_INPUT_CAPTURE = 12'h0ef8;
  localparam logic [11:0] OFF_TEST_MODE_CONTROL = 12'h0f00;
  localparam logic [11:0] OFF_OWNERSHIP_TAG_SET = 12'h0fa0;
  localparam logic [11:0] OFF_OWNERSHIP_TAG_CLEAR = 12'h0fa4;
  localparam logic [11:0] OFF_DEBUG_PERMISSION_STATUS = 12'h0fb8;
  localparam logic [11:0] OFF_CAPABILITY_WORD = 12'h0fc8;

  // ==========================================================================
  // Field positions
  localparam int unsigned SYNC_REQUEST_DRIVE_BIT = 2;
  localparam int unsigned FLUSH_VALID_DRIVE_BIT = 1;
  localparam int unsigned SLAVE_READY_DRIVE_BIT = 0;
  localparam int unsigned TEST_MODE_BIT = 0;
  localparam int unsigned SOURCE_ID_W = 7;
  localparam int unsigned BYTE_COUNT_W = 4;
  localparam int unsigned BYTE_COUNT_LSB = 8;
  localparam int unsigned WAKE_REQUEST_BIT = 2;
  localparam int unsigned FLUSH_ACK_BIT = 1;
  localparam int unsigned DATA_VALID_BIT = 0;
  localparam int unsigned TAG_W = 4;
  localparam int unsigned PERM_W = 2;

  // ==========================================================================
  // Reset and fixed values
  localparam logic [3:0] TAG_RESET = 4'h0;
  localparam logic [3:0] TAG_ALL_IMPL = 4'hf;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [2:0] OVERRIDE_RESET = 3'h0;

  // Authentication field encodings
  localparam logic [1:0] PERM_NOT_IMPL = 2'h0;
  localparam logic [1:0] PERM_DISABLED = 2'h2;
  localparam logic [1:0] PERM_ENABLED = 2'h3;

  // Capability word fixed fields
  localparam logic [1:0] BUS_ATTR_FORMAT = 2'h0;
  localparam logic [1:0] SUPPORTED_MODES = 2'h1;
  localparam logic NO_GATHER_LIST_FLAG = 1'b1;
  localparam logic MEM_ADDRESS_WIDTH_OK = 1'b1;
  localparam logic [1:0] CAP_RSVD_15_14 = 2'h0;
  localparam logic [1:0] SINK_VARIANT = 2'h0;
  localparam logic RAM_CLOCKING = 1'b0;
  localparam logic [4:0] INPUT_MUX_LEVEL = 5'h00;

  // Address width codes
  localparam logic [6:0] AW_CODE_32 = 7'h20;
  localparam logic [6:0] AW_CODE_40 = 7'h28;
  localparam logic [6:0] AW_CODE_44 = 7'h2c;
  localparam logic [6:0] AW_CODE_48 = 7'h30;
  localparam logic [6:0] AW_CODE_52 = 7'h34;

  // Memory width codes
  localparam logic [2:0] MW_CODE_32 = 3'h2;
  localparam logic [2:0] MW_CODE_64 = 3'h3;
  localparam logic [2:0] MW_CODE_128 = 3'h4;
  localparam logic [2:0] MW_CODE_256 = 3'h5;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic sync_request;
    logic flush_valid;
    logic slave_ready;
  } slave_out_t;

  typedef struct packed {
    logic [3:0] byte_count;
    logic [6:0] source_id;
    logic wake_request;
    logic flush_ack;
    logic data_valid;
  } slave_in_t;

  typedef struct packed {
    logic [1:0] hyp_noninvasive_state;
    logic [1:0] hyp_invasive_state;
    logic [1:0] secure_noninvasive_state;
    logic [1:0] secure_invasive_state;
    logic [1:0] nonsecure_noninvasive_state;
    logic [1:0] nonsecure_invasive_state;
  } perm_t;

endpackage

// ---- core/perm_encode.sv ----
// Encoder of the debug permission inputs into the status field layout
`timescale 1ns/1ps
module perm_encode (
  // Raw permission levels, per field: implemented flag and enable
  input wire logic [5:0] impl_i,
  input wire logic [5:0] enable_i,
  // Encoded fields
  output sink_regs_pkg::perm_t perm_o
);

  // ==========================================================================
  // Field encoding
  function automatic logic [1:0] enc(input logic impl, input logic en);
    if (!impl) begin
      enc = sink_regs_pkg::PERM_NOT_IMPL;
    end else if (en) begin
      enc = sink_regs_pkg::PERM_ENABLED;
    end else begin
      enc = sink_regs_pkg::PERM_DISABLED;
    end
  endfunction

  // Index 5 is the hypervisor non-invasive field, index 0 non-secure invasive
  assign perm_o.hyp_noninvasive_state = enc(impl_i[5], enable_i[5]);
  assign perm_o.hyp_invasive_state = enc(impl_i[4], enable_i[4]);
  assign perm_o.secure_noninvasive_state = enc(impl_i[3], enable_i[3]);
  assign perm_o.secure_invasive_state = enc(impl_i[2], enable_i[2]);
  assign perm_o.nonsecure_noninvasive_state = enc(impl_i[1], enable_i[1]);
  assign perm_o.nonsecure_invasive_state = enc(impl_i[0], enable_i[0]);

endmodule

// ---- core/trace_sink_test_and_id_regs.sv ----
// Management register bank of the trace buffer sink: test, ownership, status, capability
//
// Functional notes
// - in test mode override bits 2/1/0 drive sync request, flush valid, ready.
// - with test mode off, test registers read zero and ignore writes.
// - in test mode, override register reads back zero.
// - trace id capture returns live 7-bit source id in test mode.
// - input capture returns byte count, wake, flush ack, valid in test mode.
// - control bit 0 selects test mode; resets to functional mode.
// - tag set write sets each tag bit written as one.
// - tag set read returns all four implemented bits as ones.
// - tag clear write clears ones; its read returns current tag.
// - tag resets to zero and steers no other hardware.
// - permission status holds six two-bit fields in documented order.
// - field codes: 0 absent, 1 reserved, 2 disabled, 3 enabled.
// - capability bits 28:27 read 0b00.
// - capability bits 26:25 read 0b01.
// - capability bit 24 reads one, no gather-list mode.
// - capability bits 23:17 give the memory address width code.
// - capability bit 16 reads one, address width valid.
// - capability bits 13:11 give log2 of write queue depth.
// - capability bits 10:8 encode memory data width.
// - capability bit 5 reads zero, synchronous buffer RAM.
// - capability bits 4:0 read zero, no hidden input mux.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module trace_sink_test_and_id_regs #(
  parameter int unsigned MEM_ADDR_BITS = 32,
  parameter int unsigned WRITE_QUEUE_PARAM = 4,
  parameter int unsigned TRACE_DATA_BITS = 32
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [sink_regs_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [sink_regs_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [sink_regs_pkg::DATA_W-1:0] reg_rdata_o,
  // Slave port pins from the upstream source
  input wire sink_regs_pkg::slave_in_t slave_in_i,
  // Slave outputs from the functional logic
  input wire sink_regs_pkg::slave_out_t func_out_i,
  // Slave port pins toward the upstream source
  output sink_regs_pkg::slave_out_t slave_out_o,
  // Debug permission inputs, index 5 hypervisor non-invasive down to 0
  input wire logic [5:0] perm_impl_i,
  input wire logic [5:0] perm_enable_i,
  // State for the rest of the sink
  output logic test_mode_o,
  output logic [sink_regs_pkg::TAG_W-1:0] ownership_tag_o
);

  // ==========================================================================
  // Capability field functions
  function automatic logic [6:0] aw_code(input int unsigned bits);
    case (bits)
      40: aw_code = sink_regs_pkg::AW_CODE_40;
      44: aw_code = sink_regs_pkg::AW_CODE_44;
      48: aw_code = sink_regs_pkg::AW_CODE_48;
      52: aw_code = sink_regs_pkg::AW_CODE_52;
      default: aw_code = sink_regs_pkg::AW_CODE_32;
    endcase
  endfunction

  function automatic logic [2:0] mw_code(input int unsigned bits);
    case (bits)
      64: mw_code = sink_regs_pkg::MW_CODE_64;
      128: mw_code = sink_regs_pkg::MW_CODE_128;
      256: mw_code = sink_regs_pkg::MW_CODE_256;
      default: mw_code = sink_regs_pkg::MW_CODE_32;
    endcase
  endfunction

  localparam logic [2:0] WQ_LOG = 3'($clog2(WRITE_QUEUE_PARAM));

  // ==========================================================================
  // Pin synchronisers for the slave inputs and permission levels
  sink_regs_pkg::slave_in_t in_meta_r;
  sink_regs_pkg::slave_in_t in_sync_r;
  logic [11:0] perm_meta_r;
  logic [11:0] perm_sync_r;

  // Second stage is the only reader of the first
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_meta_r <= '0;
      in_sync_r <= '0;
      perm_meta_r <= '0;
      perm_sync_r <= '0;
    end else begin
      in_meta_r <= slave_in_i;
      in_sync_r <= in_meta_r;
      perm_meta_r <= {perm_impl_i, perm_enable_i};
      perm_sync_r <= perm_meta_r;
    end
  end

  // ==========================================================================
  // Permission status encoding
  sink_regs_pkg::perm_t perm_w;

  perm_encode u_perm_encode (
    .impl_i(perm_sync_r[11:6]),
    .enable_i(perm_sync_r[5:0]),
    .perm_o(perm_w)
  );

  // ==========================================================================
  // Address decode
  wire hit_override = reg_addr_i == sink_regs_pkg::OFF_SLAVE_OUTPUT_OVERRIDE;
  wire hit_id_cap = reg_addr_i == sink_regs_pkg::OFF_SLAVE_TRACE_ID_CAPTURE;
  wire hit_in_cap = reg_addr_i == sink_regs_pkg::OFF_SLAVE_INPUT_CAPTURE;
  wire hit_ctrl = reg_addr_i == sink_regs_pkg::OFF_TEST_MODE_CONTROL;
  wire hit_tag_set = reg_addr_i == sink_regs_pkg::OFF_OWNERSHIP_TAG_SET;
  wire hit_tag_clr = reg_addr_i == sink_regs_pkg::OFF_OWNERSHIP_TAG_CLEAR;
  wire hit_perm = reg_addr_i == sink_regs_pkg::OFF_DEBUG_PERMISSION_STATUS;
  wire hit_cap = reg_addr_i == sink_regs_pkg::OFF_CAPABILITY_WORD;

  // ==========================================================================
  // Control state
  logic test_mode_r;
  logic test_mode_nxt;
  logic [2:0] override_r;
  logic [2:0] override_nxt;
  logic [sink_regs_pkg::TAG_W-1:0] tag_r;
  logic [sink_regs_pkg::TAG_W-1:0] tag_nxt;

  // Test mode enable, plain read-write bit
  assign test_mode_nxt = (reg_write_i && hit_ctrl) ?
      reg_wdata_i[sink_regs_pkg::TEST_MODE_BIT] : test_mode_r;

  // Override writes only land while test mode is on, else they vanish
  wire override_we = reg_write_i && hit_override && test_mode_r;
  assign override_nxt = override_we ? reg_wdata_i[2:0] : override_r;

  // Set and clear sit at different addresses, so they never collide
  wire tag_set_we = reg_write_i && hit_tag_set;
  wire tag_clr_we = reg_write_i && hit_tag_clr;
  assign tag_nxt = tag_set_we ? (tag_r | reg_wdata_i[sink_regs_pkg::TAG_W-1:0]) :
                   tag_clr_we ? (tag_r & ~reg_wdata_i[sink_regs_pkg::TAG_W-1:0]) :
                   tag_r;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      test_mode_r <= 1'b0;
      override_r <= sink_regs_pkg::OVERRIDE_RESET;
      tag_r <= sink_regs_pkg::TAG_RESET;
    end else begin
      test_mode_r <= test_mode_nxt;
      override_r <= override_nxt;
      tag_r <= tag_nxt;
    end
  end

  // ==========================================================================
  // Slave output selection, registered so the pins come from flops
  sink_regs_pkg::slave_out_t ovr_w;
  sink_regs_pkg::slave_out_t out_sel_w;
  sink_regs_pkg::slave_out_t out_r;

  assign ovr_w.sync_request = override_r[sink_regs_pkg::SYNC_REQUEST_DRIVE_BIT];
  assign ovr_w.flush_valid = override_r[sink_regs_pkg::FLUSH_VALID_DRIVE_BIT];
  assign ovr_w.slave_ready = override_r[sink_regs_pkg::SLAVE_READY_DRIVE_BIT];
  // Costs one cycle of latency on the functional path to keep outputs glitch free
  assign out_sel_w = test_mode_r ? ovr_w : func_out_i;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_r <= '0;
    end else begin
      out_r <= out_sel_w;
    end
  end

  // ==========================================================================
  // Read views
  logic [31:0] id_view_w;
  logic [31:0] in_view_w;
  logic [31:0] perm_view_w;
  logic [31:0] cap_view_w;

  assign id_view_w = {25'h000_0000, in_sync_r.source_id};
  assign in_view_w = {20'h0_0000, in_sync_r.byte_count, 5'h00,
                      in_sync_r.wake_request, in_sync_r.flush_ack, in_sync_r.data_valid};
  assign perm_view_w = {20'h0_0000, perm_w};
  assign cap_view_w = {3'h0,
                       sink_regs_pkg::BUS_ATTR_FORMAT,
                       sink_regs_pkg::SUPPORTED_MODES,
                       sink_regs_pkg::NO_GATHER_LIST_FLAG,
                       aw_code(MEM_ADDR_BITS),
                       sink_regs_pkg::MEM_ADDRESS_WIDTH_OK,
                       sink_regs_pkg::CAP_RSVD_15_14,
                       WQ_LOG,
                       mw_code(TRACE_DATA_BITS),
                       sink_regs_pkg::SINK_VARIANT,
                       sink_regs_pkg::RAM_CLOCKING,
                       sink_regs_pkg::INPUT_MUX_LEVEL};

  // Read mux; override reads zero in either mode, captures zero outside test mode
  logic [31:0] rd_mux_w;
  assign rd_mux_w = (hit_id_cap && test_mode_r) ? id_view_w :
                    (hit_in_cap && test_mode_r) ? in_view_w :
                    hit_override ? sink_regs_pkg::ZERO_WORD :
                    hit_ctrl ? {31'h0000_0000, test_mode_r} :
                    hit_tag_set ? {28'h000_0000, sink_regs_pkg::TAG_ALL_IMPL} :
                    hit_tag_clr ? {28'h000_0000, tag_r} :
                    hit_perm ? perm_view_w :
                    hit_cap ? cap_view_w :
                    sink_regs_pkg::ZERO_WORD;

  // Read data stand only in the cycle after the strobe
  logic [31:0] rdata_r;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= sink_regs_pkg::ZERO_WORD;
    end else begin
      rdata_r <= reg_read_i ? rd_mux_w : sink_regs_pkg::ZERO_WORD;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata_o = rdata_r;
  assign slave_out_o = out_r;
  assign test_mode_o = test_mode_r;
  // Informational only; nothing in the sink acts on it
  assign ownership_tag_o = tag_r;

endmodule

// ---- dv/sink_regs_props.sv ----
// Checker of the sink management register bank as seen at its ports
`timescale 1ns/1ps
module sink_regs_props (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [31:0] reg_rdata_o,
  // Slave outputs and state
  input wire sink_regs_pkg::slave_out_t func_out_i,
  input wire sink_regs_pkg::slave_out_t slave_out_o,
  input wire logic test_mode_o,
  input wire logic [3:0] ownership_tag_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  // Decoded strobes, named so each property reads plainly
  wire w_set = reg_write_i && reg_addr_i == 12'h0fa0;
  wire w_clr = reg_write_i && reg_addr_i == 12'h0fa4;
  wire w_ovr = reg_write_i && reg_addr_i == 12'h0ef0;
  wire w_mode = reg_write_i && reg_addr_i == 12'h0f00;
  wire r_clr = reg_read_i && reg_addr_i == 12'h0fa4;
  wire r_test = reg_read_i && (reg_addr_i inside {12'h0ef0, 12'h0ef4, 12'h0ef8});
  // ==========================================================================
  // Ownership tag
  AST_TAG_SET: assert property (
    w_set |=> ownership_tag_o == ($past(ownership_tag_o) | $past(reg_wdata_i[3:0])))
    else $error("tag set result wrong");
  AST_TAG_CLR: assert property (
    w_clr |=> ownership_tag_o == ($past(ownership_tag_o) & ~$past(reg_wdata_i[3:0])))
    else $error("tag clear result wrong");
  AST_SET_VIEW: assert property (
    reg_read_i && reg_addr_i == 12'h0fa0 |=> reg_rdata_o == 32'h0000_000f)
    else $error("set view not all ones");
  AST_CLR_VIEW: assert property (
    r_clr |=> reg_rdata_o == {28'h0, $past(ownership_tag_o)})
    else $error("clear view not current tag");
  // ==========================================================================
  // Test mode registers, slave outputs and capability word
  AST_TEST_OFF: assert property (
    r_test && !test_mode_o |=> reg_rdata_o == 32'h0000_0000)
    else $error("test register not zero in functional mode");
  AST_OVR_RAZ: assert property (
    reg_read_i && reg_addr_i == 12'h0ef0 |=> reg_rdata_o == 32'h0000_0000)
    else $error("override read not zero");
  AST_MODE: assert property (
    w_mode |=> test_mode_o == $past(reg_wdata_i[0]))
    else $error("mode bit not taken");
  AST_OVR_DRIVE: assert property (
    w_ovr && test_mode_o |=> ##1 slave_out_o == $past(reg_wdata_i[2:0], 2))
    else $error("override not on slave outputs");
  AST_FUNC_PATH: assert property (
    !test_mode_o |=> slave_out_o == $past(func_out_i))
    else $error("functional outputs not passed");
  AST_CAP_WORD: assert property (
    reg_read_i && reg_addr_i == 12'h0fc8 |=> reg_rdata_o == 32'h0341_1200)
    else $error("capability word wrong");
endmodule

bind trace_sink_test_and_id_regs sink_regs_props chk (
  .clock_i(clock_i),
  .rst_b_i(rst_b_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_write_i(reg_write_i),
  .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o),
  .func_out_i(func_out_i),
  .slave_out_o(slave_out_o),
  .test_mode_o(test_mode_o),
  .ownership_tag_o(ownership_tag_o)
);

// ---- dv/trace_source_model.sv ----
// Model of the upstream trace source holding the slave port input pins
`timescale 1ns/1ps
module trace_source_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Request for a new pin pattern
  input wire logic step_i,
  // Slave port pins toward the sink
  output sink_regs_pkg::slave_in_t pins_o
);
  integer seed = 32'h4ecf17e2;
  // Pins move only on request, so a capture read sees a settled pattern
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_o <= 14'h0000;
    end else if (step_i) begin
      pins_o <= 14'($random(seed));
    end
  end
endmodule

// ---- dv/trace_sink_test_and_id_regs_tb_top.sv ----
// Self-checking bench of the sink management register bank
`timescale 1ns/1ps
module trace_sink_test_and_id_regs_tb_top;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic step = 1'b0;
  logic [5:0] impl = 6'h00;
  logic [5:0] en = 6'h00;
  sink_regs_pkg::slave_out_t func = 3'h0;
  sink_regs_pkg::slave_out_t sout;
  sink_regs_pkg::slave_in_t pins;
  logic [31:0] rdata;
  logic tmode;
  logic [3:0] tag;
  logic [3:0] tag_exp;
  logic [31:0] tag_wd;
  sink_regs_pkg::slave_out_t func_d;
  integer seed = 32'h4ecf17e2;
  int n_fail = 0;
  int num_checks = 0;
  always #2 clock_i = ~clock_i;
  // Functional outputs move every cycle so a stuck path shows
  always @(posedge clock_i) func <= 3'($random(seed));
  // Last cycle's functional value, what the registered slave outputs should show now
  always @(posedge clock_i) func_d <= func;
  trace_sink_test_and_id_regs uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata),
    .slave_in_i(pins), .func_out_i(func), .slave_out_o(sout), .perm_impl_i(impl),
    .perm_enable_i(en), .test_mode_o(tmode), .ownership_tag_o(tag));
  trace_source_model src (.clock_i(clock_i), .rst_b_i(rst_b_i), .step_i(step), .pins_o(pins));
  // ==========================================================================
  // Bus cycles and comparison
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic check_rd(input logic [11:0] a, input logic [31:0] e, input string m);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 cmp(rdata, e, m);
  endtask
  function automatic logic [31:0] perm_exp(input logic [5:0] i, input logic [5:0] e);
    perm_exp = 32'h0000_0000;
    for (int k = 0; k < 6; k++)
      perm_exp[2*k +: 2] = i[k] ? (e[k] ? 2'h3 : 2'h2) : 2'h0;
  endfunction
  task automatic finish_test();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clock_i);
    // Release between edges so flops and checker leave reset at the same edge
    @(negedge clock_i);
    rst_b_i <= 1'b1;
    check_rd(12'h0fa4, 32'h0000_0000, "tag reset");
    check_rd(12'h0f00, 32'h0000_0000, "mode reset");
    check_rd(12'h0fa0, 32'h0000_000f, "set view");
    check_rd(12'h0fc8, 32'h0341_1200, "capability");
    check_rd(12'h0ffc, 32'h0000_0000, "unmapped");
    $display("reset values done");
    // Functional mode: writes dropped, reads zero
    for (int k = 0; k < 3; k++) begin
      wr_reg(12'h0ef0 + 12'(4 * k), $random(seed));
      check_rd(12'h0ef0 + 12'(4 * k), 32'h0000_0000, "inert test reg");
      cmp({29'h0, sout}, {29'h0, func_d}, "functional drive");
    end
    $display("functional mode done");
    // Tag: all set then all clear, then random mix
    tag_exp = 4'h0;
    for (int k = 0; k < 20; k++) begin
      tag_wd = (k == 0) ? 32'h0000_000f : (k == 1) ? 32'hffff_ffff : $random(seed);
      if (k == 1 || (k > 1 && tag_wd[31])) begin
        wr_reg(12'h0fa4, tag_wd);
        tag_exp = tag_exp & ~tag_wd[3:0];
      end else begin
        wr_reg(12'h0fa0, tag_wd);
        tag_exp = tag_exp | tag_wd[3:0];
      end
      check_rd(12'h0fa4, {28'h0, tag_exp}, "tag value");
      cmp({28'h0, tag}, {28'h0, tag_exp}, "tag port");
    end
    $display("ownership tag done");
    // Test mode: overrides reach the slave outputs for every pattern
    wr_reg(12'h0f00, 32'h0000_0001);
    check_rd(12'h0f00, 32'h0000_0001, "mode on");
    cmp({31'h0, tmode}, 32'h0000_0001, "mode port");
    for (int k = 0; k < 8; k++) begin
      wr_reg(12'h0ef0, 32'(k));
      repeat (2) @(posedge clock_i);
      #1 cmp({29'h0, sout}, 32'(k), "override drive");
      check_rd(12'h0ef0, 32'h0000_0000, "override read");
    end
    // Capture of the live source pins; writes there are dropped
    for (int k = 0; k < 8; k++) begin
      step <= 1'b1;
      @(posedge clock_i);
      step <= 1'b0;
      wr_reg(12'h0ef4, $random(seed));
      repeat (3) @(posedge clock_i);
      check_rd(12'h0ef4, {25'h0, pins.source_id}, "id capture");
      check_rd(12'h0ef8, {20'h0, pins.byte_count, 5'h0, pins.wake_request,
        pins.flush_ack, pins.data_valid}, "input capture");
    end
    $display("test mode done");
    // Permission status across random levels
    for (int k = 0; k < 10; k++) begin
      impl <= (k == 0) ? 6'h00 : 6'($random(seed));
      en <= 6'($random(seed));
      repeat (4) @(posedge clock_i);
      check_rd(12'h0fb8, perm_exp(impl, en), "permission");
    end
    $display("permission done");
    // Leave test mode; a reset in mid-run clears the tag
    wr_reg(12'h0f00, 32'h0000_0000);
    check_rd(12'h0ef8, 32'h0000_0000, "capture off");
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    rst_b_i <= 1'b1;
    check_rd(12'h0fa4, 32'h0000_0000, "tag after reset");
    $display("exit and reset done");
    finish_test();
  end
  // Watchdog well past the few hundred cycles the sequence needs
  initial begin
    #40000;
    n_fail++;
    finish_test();
  end
endmodule
